// ==== dv/testbench.sv ====
module testbench
  import wpcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, wr, rd, ap, flag, fdiv, htx, rxc, ext;
  logic        trig, ctx, tmode, tloop, cmode, cbeg, rarm, avalid, dwake, twake, amatch;
  logic [8:0]  ev;
  logic [15:0] addr, conv;
  logic [31:0] wdata, rdata, stamp, d;
  logic [25:0] alloc_vector_now;
  logic [47:0] rxa, owna;
  logic [10:0] tlen;
  logic [7:0]  cbyte;
  logic [5:0]  ackp, ctsp;
  logic [3:0]  txant, lant;
  logic [2:0]  ps;
  int          n_mismatch, n_tests, cyc;
  localparam logic [15:0] RW_OFS [8] = '{OFS_CONV_TEST, OFS_DEF_ANT, OFS_DTIM_CFG, OFS_TIM_CFG,
    OFS_PERIODS, OFS_MASK_LOW, OFS_MASK_HIGH, OFS_RESP_PWR};
  localparam logic [31:0] RW_RST [8] = '{RST_CONV_TEST, RST_DEF_ANT, RST_DTIM_CFG, RST_TIM_CFG & MSK_TIM_CFG,
    RST_PERIODS, RST_MASK_LOW, RST_MASK_HIGH, RST_RESP_PWR & MSK_RESP_PWR};
  localparam logic [31:0] RW_MSK [8] = '{MSK_CONV_TEST, MSK_DEF_ANT, MSK_DTIM_CFG, MSK_TIM_CFG,
    32'hffff_ffff, 32'hffff_ffff, MSK_MASK_HIGH, MSK_RESP_PWR};
  localparam logic [15:0] CNT_OFS [5] = '{OFS_HS_OK, OFS_HS_FAIL, OFS_ACK_MISS, OFS_CRC_FAIL, OFS_BCN_CNT};

  wpcu_regs #(.TU_COUNT(4)) u_wpcu_regs (
    .CLOCK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .TIMER_TICK(ev[7]), .BEACON_SEEN(ev[4]), .BEACON_STAMP(stamp), .CAB_SEEN(ev[8]), .ALLOC_VECTOR(alloc_vector_now),
    .HS_OK_EVT(ev[0]), .HS_FAIL_EVT(ev[1]), .ACK_MISS_EVT(ev[2]), .CRC_FAIL_EVT(ev[3]),
    .CONV_DATA(conv), .RX_CLEAR(rxc), .EXT_TRIGGER(ext), .CONV_BYTE(cbyte), .CAPTURE_TRIGGER(trig),
    .CONT_TX_MODE(ctx), .TEST_MODE(tmode), .TEST_LOOP_EN(tloop), .TEST_LOOP_LENGTH(tlen),
    .CAPTURE_MODE(cmode), .CAPTURE_BEGIN(cbeg), .RX_BUFFER_ARM(rarm), .AP_MODE(ap),
    .USE_DEFAULT_ANTENNA_FLAG(flag), .FAST_DIVERSITY(fdiv), .HOST_FRAME_TX(htx), .ANT_GOOD_EVT(ev[6]),
    .ANT_BAD_EVT(ev[5]), .TX_ANTENNA(txant), .LISTEN_ANTENNA(lant), .ANTENNA_VALID(avalid),
    .DTIM_WAKE(dwake), .TIM_WAKE(twake), .PS_STATE(ps), .RX_ADDR(rxa), .OWN_ADDR(owna), .ADDR_MATCH(amatch),
    .ACK_RESPONSE_POWER(ackp), .CTS_RESPONSE_POWER(ctsp));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr32(logic [15:0] a, logic [31:0] v);
    @(posedge clk) #1 wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge clk) #1 wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd32(logic [15:0] a);
    @(posedge clk) #1 rd = 1'b1;
    addr = a;
    @(posedge clk) #1 rd = 1'b0;
    d = rdata;
  endtask
  task automatic pulse(int i, int n);
    repeat (n) begin
      @(posedge clk) #1 ev[i] = 1'b1;
      @(posedge clk) #1 ev[i] = 1'b0;
    end
  endtask
  task automatic wait_ps(logic [2:0] e, int lim);
    for (int k = 0; k < lim && ps !== e; k++) @(posedge clk) #1;
    chk("ps_state", {29'h0, ps}, {29'h0, e});
  endtask
  task automatic catch_trig(int lim, logic exp);
    logic got;
    got = 1'b0;
    repeat (lim) @(posedge clk) #1 got = got | trig;
    chk("capture_trigger", {31'h0, got}, {31'h0, exp});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_rw();
    wr32(OFS_TIMER_LOW, 32'h1234_5678);
    wr32(OFS_TIMER_HIGH, 32'h9abc_def0);
    @(posedge clk) #1 srst = 1'b1;
    @(posedge clk) #1 srst = 1'b0;
    rd32(OFS_TIMER_LOW); chk("timer_low", d, 32'h1234_5678);
    rd32(OFS_TIMER_HIGH); chk("timer_high", d, 32'h9abc_def0);
    chk("resp_power", {20'h0, ctsp, ackp}, 32'h0000_0fff);
    for (int i = 0; i < 8; i++) begin
      rd32(RW_OFS[i]); chk("reset_value", d, RW_RST[i]);
      wr32(RW_OFS[i], 32'hffff_ffff);
      rd32(RW_OFS[i]); chk("reserved_bits", d, RW_MSK[i]);
    end
    chk("test_bits", {15'h0, ctx, tmode, tloop, tlen, cmode, cbeg, rarm}, 32'h0001_ffff);
    wr32(OFS_CONV_TEST, 32'h0000_0012);
    chk("loop_length", {21'h0, tlen}, 32'h0000_0002);
    wr32(OFS_RESP_PWR, 32'h0000_2a15);
    chk("resp_power", {20'h0, ctsp, ackp}, 32'h0000_0a95);
    alloc_vector_now = 26'h3ff_ffff;
    wr32(OFS_ALLOC_VEC, 32'h0);
    rd32(OFS_ALLOC_VEC); chk("alloc_vector", d, 32'h03ff_ffff);
    wr32(16'h805c, 32'hffff_ffff);
    rd32(16'h805c); chk("unmapped", d, 32'h0);
    $display("test reset_rw done");
  endtask

  task automatic t_counters();
    for (int i = 0; i < 5; i++) begin
      pulse(i, i + 2);
      rd32(CNT_OFS[i]); chk("count", d, i + 2);
      rd32(CNT_OFS[i]); chk("count_cleared", d, 32'h0);
    end
    @(posedge clk) #1 ev[2] = 1'b1;
    repeat (65540) @(posedge clk);
    #1 ev[2] = 1'b0;
    rd32(OFS_ACK_MISS); chk("saturated", d, 32'h0000_ffff);
    rd32(OFS_ACK_MISS); chk("count_cleared", d, 32'h0);
    stamp = 32'hc0de_1234;
    pulse(4, 1);
    rd32(OFS_LAST_STAMP); chk("beacon_stamp", d, 32'hc0de_1234);
    rd32(OFS_BCN_CNT); chk("beacon_count", d, 32'h1);
    $display("test counters done");
  endtask

  task automatic t_converter();
    conv = 16'ha55a;
    wr32(OFS_CONV_TEST, 32'h0002_4000);
    repeat (2) @(posedge clk) #1;
    chk("conv_upper", {24'h0, cbyte}, 32'h0000_00a5);
    rxc = 1'b1;
    catch_trig(8, 1'b1);
    rxc = 1'b0;
    catch_trig(8, 1'b0);
    wr32(OFS_CONV_TEST, 32'h0001_0000);
    repeat (2) @(posedge clk) #1;
    chk("conv_lower", {24'h0, cbyte}, 32'h0000_005a);
    ext = 1'b1;
    catch_trig(8, 1'b0);
    ext = 1'b0;
    catch_trig(8, 1'b1);
    $display("test converter done");
  endtask

  task automatic t_antenna();
    wr32(OFS_DEF_ANT, 32'h1);
    pulse(5, 8);
    rd32(OFS_DEF_ANT); chk("station_adapt", d, 32'h2);
    ap = 1'b1;
    pulse(5, 8);
    rd32(OFS_DEF_ANT); chk("ap_fixed", d, 32'h2);
    flag = 1'b1;
    htx = 1'b1;
    @(posedge clk) #1 chk("tx_antenna", {28'h0, txant}, 32'h2);
    fdiv = 1'b1;
    @(posedge clk) #1 chk("listen_div", {28'h0, lant}, 32'h0);
    fdiv = 1'b0;
    for (int v = 0; v < 16; v++) begin
      wr32(OFS_DEF_ANT, v);
      chk("antenna_valid", {31'h0, avalid}, {31'h0, v != 0 && v != 15});
    end
    wr32(OFS_MASK_LOW, 32'hffff_fff0);
    owna = 48'h0123_4567_89ab;
    rxa = owna ^ 48'h5;
    @(posedge clk) #1 chk("masked_match", {31'h0, amatch}, 32'h1);
    rxa = owna ^ 48'h10;
    @(posedge clk) #1 chk("unmasked_miss", {31'h0, amatch}, 32'h0);
    $display("test antenna done");
  endtask

  task automatic t_power_save();
    wr32(OFS_PERIODS, 32'h0003_0002);
    wr32(OFS_TIM_CFG, 32'h0200_0100);
    wr32(OFS_DTIM_CFG, 32'h0108_0200);
    wr32(OFS_TIMER_LOW, 32'h0000_00ff);
    pulse(7, 1);
    chk("tim_wake", {31'h0, twake}, 32'h1);
    wait_ps(WPCU_BCN, 4);
    pulse(4, 1);
    wait_ps(WPCU_CAB, 3);
    wait_ps(WPCU_IDLE, 12);
    rd32(OFS_TIM_CFG); chk("tim_advance", d, 32'h0200_0110);
    wr32(OFS_TIMER_LOW, 32'h0000_01ff);
    pulse(7, 1);
    wait_ps(WPCU_BCN, 4);
    wait_ps(WPCU_CAB, 16);
    wait_ps(WPCU_IDLE, 12);
    rd32(OFS_DTIM_CFG); chk("dtim_advance", d, 32'h0108_0218);
    wr32(OFS_DTIM_CFG, 32'h0118_0300);
    wr32(OFS_TIMER_LOW, 32'h0000_02ff);
    pulse(7, 1);
    chk("dtim_wake", {31'h0, dwake}, 32'h0);
    repeat (6) @(posedge clk) #1;
    chk("sleep_ignores", {29'h0, ps}, {29'h0, WPCU_IDLE});
    $display("test power_save done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    {clk, srst, wr, rd, ap, flag, fdiv, htx, rxc, ext} = 10'h100;
    {ev, addr, conv, wdata, stamp, alloc_vector_now, rxa, owna} = '0;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    t_reset_rw();
    t_counters();
    t_converter();
    t_antenna();
    t_power_save();
    summarize();
  end
endmodule

// ==== dv/wpcu_regs_asserts.sv ====
module wpcu_regs_asserts
  import wpcu_pkg::*;
#(
  parameter int TU_COUNT = 4
) (
  // Clock and host port
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic [15:0] REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Events
  input wire logic        BEACON_SEEN,
  input wire logic [31:0] BEACON_STAMP,
  input wire logic        HS_OK_EVT,
  input wire logic [25:0] ALLOC_VECTOR,
  // Antenna
  input wire logic        USE_DEFAULT_ANTENNA_FLAG,
  input wire logic        HOST_FRAME_TX,
  input wire logic        FAST_DIVERSITY,
  input wire logic [3:0]  TX_ANTENNA,
  input wire logic [3:0]  LISTEN_ANTENNA,
  input wire logic        ANTENNA_VALID,
  // Power save and address match
  input wire logic        DTIM_WAKE,
  input wire logic        TIM_WAKE,
  input wire logic [2:0]  PS_STATE,
  input wire logic [47:0] RX_ADDR,
  input wire logic [47:0] OWN_ADDR,
  input wire logic        ADDR_MATCH
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_rd_ok;
    REG_RD && REG_ADDR == OFS_HS_OK && !HS_OK_EVT;
  endsequence
  sequence s_bcn_rd;
    BEACON_SEEN ##2 (REG_RD && REG_ADDR == OFS_LAST_STAMP && !$past(BEACON_SEEN));
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_nav_read: assert property (REG_RD && REG_ADDR == OFS_ALLOC_VEC |=>
    REG_RDATA == {6'h0, $past(ALLOC_VECTOR)}) else $error("alloc vector read wrong");
  a_stamp_capture: assert property (s_bcn_rd |=> REG_RDATA == $past(BEACON_STAMP, 3))
    else $error("beacon stamp not captured");
  a_count_clear: assert property (s_rd_ok ##1 !HS_OK_EVT ##1 s_rd_ok |=> REG_RDATA == 32'h0)
    else $error("counter not cleared by read");
  a_tx_idle: assert property (!(USE_DEFAULT_ANTENNA_FLAG && HOST_FRAME_TX) |-> TX_ANTENNA == 4'h0)
    else $error("tx antenna driven without flag");
  a_listen_div: assert property (FAST_DIVERSITY |-> LISTEN_ANTENNA == 4'h0)
    else $error("listen antenna during diversity");
  a_ant_valid: assert property (!FAST_DIVERSITY |->
    ANTENNA_VALID == (LISTEN_ANTENNA != ANT_INVALID && LISTEN_ANTENNA != ANT_NA)) else $error("antenna valid wrong");
  a_wake_start: assert property ((DTIM_WAKE || TIM_WAKE) && PS_STATE == WPCU_IDLE |=> PS_STATE == WPCU_BCN)
    else $error("wake did not start beacon wait");
  a_bcn_to_cab: assert property (PS_STATE == WPCU_BCN && BEACON_SEEN |=> PS_STATE == WPCU_CAB)
    else $error("beacon did not start traffic wait");
  a_addr_equal: assert property (RX_ADDR == OWN_ADDR |-> ADDR_MATCH)
    else $error("equal address not matched");
endmodule

bind wpcu_regs wpcu_regs_asserts #(.TU_COUNT(TU_COUNT)) u_wpcu_regs_asserts (
  .CLOCK(CLOCK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .BEACON_SEEN(BEACON_SEEN), .BEACON_STAMP(BEACON_STAMP), .HS_OK_EVT(HS_OK_EVT), .ALLOC_VECTOR(ALLOC_VECTOR),
  .USE_DEFAULT_ANTENNA_FLAG(USE_DEFAULT_ANTENNA_FLAG), .HOST_FRAME_TX(HOST_FRAME_TX),
  .FAST_DIVERSITY(FAST_DIVERSITY), .TX_ANTENNA(TX_ANTENNA), .LISTEN_ANTENNA(LISTEN_ANTENNA),
  .ANTENNA_VALID(ANTENNA_VALID), .DTIM_WAKE(DTIM_WAKE), .TIM_WAKE(TIM_WAKE), .PS_STATE(PS_STATE),
  .RX_ADDR(RX_ADDR), .OWN_ADDR(OWN_ADDR), .ADDR_MATCH(ADDR_MATCH));

// ==== src/wpcu_pkg.sv ====
package wpcu_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] OFS_TIMER_LOW  = 16'h804c;
  localparam logic [15:0] OFS_TIMER_HIGH = 16'h8050;
  localparam logic [15:0] OFS_CONV_TEST  = 16'h8054;
  localparam logic [15:0] OFS_DEF_ANT    = 16'h8058;
  localparam logic [15:0] OFS_LAST_STAMP = 16'h8080;
  localparam logic [15:0] OFS_ALLOC_VEC  = 16'h8084;
  localparam logic [15:0] OFS_HS_OK      = 16'h8088;
  localparam logic [15:0] OFS_HS_FAIL    = 16'h808c;
  localparam logic [15:0] OFS_ACK_MISS   = 16'h8090;
  localparam logic [15:0] OFS_CRC_FAIL   = 16'h8094;
  localparam logic [15:0] OFS_BCN_CNT    = 16'h8098;
  localparam logic [15:0] OFS_DTIM_CFG   = 16'h80d4;
  localparam logic [15:0] OFS_TIM_CFG    = 16'h80d8;
  localparam logic [15:0] OFS_PERIODS    = 16'h80dc;
  localparam logic [15:0] OFS_MASK_LOW   = 16'h80e0;
  localparam logic [15:0] OFS_MASK_HIGH  = 16'h80e4;
  localparam logic [15:0] OFS_RESP_PWR   = 16'h80e8;

  // ----------------------------------------
  // Reset values and field masks
  // ----------------------------------------
  localparam logic [31:0] RST_CONV_TEST  = 32'h0000_0000;
  localparam logic [31:0] RST_DEF_ANT    = 32'h0000_0000;
  localparam logic [31:0] RST_DTIM_CFG   = 32'h0512_aaaa;
  localparam logic [31:0] RST_TIM_CFG    = 32'h0020_5555;
  localparam logic [31:0] RST_PERIODS    = 32'h0003_0002;
  localparam logic [31:0] RST_MASK_LOW   = 32'hffff_ffff;
  localparam logic [31:0] RST_MASK_HIGH  = 32'h0000_ffff;
  localparam logic [31:0] RST_RESP_PWR   = 32'h003f_3f3f;
  localparam logic [31:0] MSK_CONV_TEST  = 32'h001f_ffff;
  localparam logic [31:0] MSK_DEF_ANT    = 32'h0000_000f;
  localparam logic [31:0] MSK_DTIM_CFG   = 32'hff1f_ffff;
  localparam logic [31:0] MSK_TIM_CFG    = 32'hff07_ffff;
  localparam logic [31:0] MSK_MASK_HIGH  = 32'h0000_ffff;
  localparam logic [31:0] MSK_RESP_PWR   = 32'h0000_3f3f;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CT_CONT_TX   = 0;
  localparam int CT_TEST_MODE = 1;
  localparam int CT_LOOP_EN   = 2;
  localparam int CT_LEN_LO    = 3;
  localparam int CT_LEN_HI    = 13;
  localparam int CT_UPPER     = 14;
  localparam int CT_MSB       = 15;
  localparam int CT_TRIG_SEL  = 16;
  localparam int CT_POL       = 17;
  localparam int CT_CAPTURE   = 18;
  localparam int CT_BEGIN     = 19;
  localparam int CT_ARM       = 20;
  localparam int WK_TIME_HI   = 18;
  localparam int WK_PRESUME   = 19;
  localparam int WK_SLEEP_EN  = 20;
  localparam int WK_LIMIT_LO  = 24;
  localparam int PER_DTIM_LO  = 16;
  localparam int PWR_CTS_LO   = 8;

  // ----------------------------------------
  // Antenna codes and timing
  // ----------------------------------------
  localparam logic [3:0] ANT_INVALID = 4'h0;
  localparam logic [3:0] ANT_ONE     = 4'h1;
  localparam logic [3:0] ANT_TWO     = 4'h2;
  localparam logic [3:0] ANT_NA      = 4'hf;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam int TU_US          = 1024;
  localparam int CLK_MHZ        = 100;
  localparam int TU_CYCLES      = TU_US * CLK_MHZ;
  localparam int ANT_VOTE_LIMIT = 8;

  typedef enum logic [2:0] {
    WPCU_IDLE  = 3'b001,
    WPCU_BCN   = 3'b010,
    WPCU_CAB   = 3'b100
  } wpcu_ps_t;
endpackage

// ==== src/wpcu_regs.sv ====
// Function
// - 64-bit sync timer as two RW words, untouched by either reset.
// - Statistics counters increment per event and stop at all ones.
// - Reading a statistics counter returns it, then clears it.
// - Separate 16-bit counters for good and failed RTS/CTS exchanges.
// - 16-bit counters for failed data acks and bad-checksum frames.
// - 16-bit counter of valid received beacons.
// - Low 32 bits of last beacon timestamp held read-only.
// - Current allocation vector read-only, 26 bits, upper bits zero.
// - Test bits: continuous tx, test mode, loop enable, loop length minus one.
// - Upper-byte select returns high eight bits of converter data, else low.
// - Trigger source rx-clear or external; polarity picks falling or rising edge.
// - Bits for capture mode, capture begin and receive-buffer arm.
// - Antenna field: 0 invalid, 1 and 2 antennas, 3-14 sectors, 15 n/a.
// - AP mode keeps programmed antenna; omni station adapts toward best one.
// - Default antenna used for host frames when flagged, and for listening when fast diversity is off.
// - Station wakes for DTIM at timer match, then adds DTIM interval.
// - Station wakes for TIM at its own match, then adds TIM interval.
// - Sleep-enable bit makes wake-time expiry triggers be ignored.
// - After waking, beacon timeout; DTIM with presume goes to CAB, else idle.
// - After_beacon_traffic_limit after beacon or last CAB frame returns to idle.
// - 48-bit mask, low word and high 16 bits, resets to all ones.
// - ACK power in bits 5-0, CTS power in bits 13-8.
module wpcu_regs
  import wpcu_pkg::*;
#(
  parameter int TU_COUNT = TU_CYCLES
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  // Host register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  // Timer and beacon inputs
  input  wire logic        TIMER_TICK,
  input  wire logic        BEACON_SEEN,
  input  wire logic [31:0] BEACON_STAMP,
  input  wire logic        CAB_SEEN,
  input  wire logic [25:0] ALLOC_VECTOR,
  // Statistics events
  input  wire logic        HS_OK_EVT,
  input  wire logic        HS_FAIL_EVT,
  input  wire logic        ACK_MISS_EVT,
  input  wire logic        CRC_FAIL_EVT,
  // Converter test
  input  wire logic [15:0] CONV_DATA,
  input  wire logic        RX_CLEAR,
  input  wire logic        EXT_TRIGGER,
  output logic      [7:0]  CONV_BYTE,
  output logic             CAPTURE_TRIGGER,
  output logic             CONT_TX_MODE,
  output logic             TEST_MODE,
  output logic             TEST_LOOP_EN,
  output logic      [10:0] TEST_LOOP_LENGTH,
  output logic             CAPTURE_MODE,
  output logic             CAPTURE_BEGIN,
  output logic             RX_BUFFER_ARM,
  // Antenna
  input  wire logic        AP_MODE,
  input  wire logic        USE_DEFAULT_ANTENNA_FLAG,
  input  wire logic        FAST_DIVERSITY,
  input  wire logic        HOST_FRAME_TX,
  input  wire logic        ANT_GOOD_EVT,
  input  wire logic        ANT_BAD_EVT,
  output logic      [3:0]  TX_ANTENNA,
  output logic      [3:0]  LISTEN_ANTENNA,
  output logic             ANTENNA_VALID,
  // Power save
  output logic             DTIM_WAKE,
  output logic             TIM_WAKE,
  output logic      [2:0]  PS_STATE,
  // Address match
  input  wire logic [47:0] RX_ADDR,
  input  wire logic [47:0] OWN_ADDR,
  output logic             ADDR_MATCH,
  // Response power
  output logic      [5:0]  ACK_RESPONSE_POWER,
  output logic      [5:0]  CTS_RESPONSE_POWER
);
  if (TU_COUNT < 1) begin
    $error("TU_COUNT must be at least one");
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [63:0] timer_q;
  logic [31:0] conv_q;
  logic [3:0]  ant_q;
  logic [31:0] stamp_q;
  logic [31:0] dtim_cfg_q;
  logic [31:0] tim_cfg_q;
  logic [31:0] periods_q;
  logic [31:0] mask_low_q;
  logic [15:0] mask_high_q;
  logic [13:0] pwr_q;
  logic        wr_timer_lo;
  logic        wr_timer_hi;
  logic        wr_dtim;
  logic        wr_tim;

  assign wr_timer_lo = REG_WR && REG_ADDR == OFS_TIMER_LOW;
  assign wr_timer_hi = REG_WR && REG_ADDR == OFS_TIMER_HIGH;
  assign wr_dtim     = REG_WR && REG_ADDR == OFS_DTIM_CFG;
  assign wr_tim      = REG_WR && REG_ADDR == OFS_TIM_CFG;

  // Timer keeps running through reset; no reset branch on purpose
  always_ff @(posedge CLOCK) begin
    if (wr_timer_lo) begin
      timer_q[31:0] <= REG_WDATA;
    end else if (wr_timer_hi) begin
      timer_q[63:32] <= REG_WDATA;
    end else if (TIMER_TICK) begin
      timer_q <= timer_q + 64'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (BEACON_SEEN) begin
      stamp_q <= BEACON_STAMP;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      conv_q      <= RST_CONV_TEST;
      mask_low_q  <= RST_MASK_LOW;
      mask_high_q <= RST_MASK_HIGH[15:0];
      pwr_q       <= RST_RESP_PWR[13:0];
      periods_q   <= RST_PERIODS;
    end else if (REG_WR) begin
      case (REG_ADDR)
        OFS_CONV_TEST: conv_q      <= REG_WDATA & MSK_CONV_TEST;
        OFS_MASK_LOW:  mask_low_q  <= REG_WDATA;
        OFS_MASK_HIGH: mask_high_q <= REG_WDATA[15:0];
        OFS_RESP_PWR:  pwr_q       <= REG_WDATA[13:0] & MSK_RESP_PWR[13:0];
        OFS_PERIODS:   periods_q   <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Converter test
  // ----------------------------------------
  logic [2:0] trig_sync_q;
  logic       trig_src;
  logic       trig_level_q;

  assign trig_src = conv_q[CT_TRIG_SEL] ? EXT_TRIGGER : RX_CLEAR;

  // Both sources come from outside the core clock; three-stage sample
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      trig_sync_q  <= 3'h0;
      trig_level_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], trig_src};
      if (trig_sync_q[1] == trig_sync_q[2]) begin
        trig_level_q <= trig_sync_q[2];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      CAPTURE_TRIGGER <= 1'b0;
      CONV_BYTE       <= 8'h00;
    end else begin
      CAPTURE_TRIGGER <= (trig_sync_q[1] == trig_sync_q[2]) && (trig_sync_q[2] != trig_level_q)
                         && (trig_sync_q[2] == conv_q[CT_POL]);
      CONV_BYTE <= conv_q[CT_UPPER] ? CONV_DATA[15:8] : CONV_DATA[7:0];
    end
  end

  assign CONT_TX_MODE     = conv_q[CT_CONT_TX];
  assign TEST_MODE        = conv_q[CT_TEST_MODE];
  assign TEST_LOOP_EN     = conv_q[CT_LOOP_EN];
  assign TEST_LOOP_LENGTH = conv_q[CT_LEN_HI:CT_LEN_LO];
  assign CAPTURE_MODE     = conv_q[CT_CAPTURE];
  assign CAPTURE_BEGIN    = conv_q[CT_BEGIN];
  assign RX_BUFFER_ARM    = conv_q[CT_ARM];

  // ----------------------------------------
  // Default antenna
  // ----------------------------------------
  logic [3:0] vote_q;

  // Station mode swaps antenna 1 and 2 after repeated bad reports
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ant_q  <= RST_DEF_ANT[3:0];
      vote_q <= 4'h0;
    end else if (REG_WR && REG_ADDR == OFS_DEF_ANT) begin
      ant_q  <= REG_WDATA[3:0] & MSK_DEF_ANT[3:0];
      vote_q <= 4'h0;
    end else if (!AP_MODE && (ant_q == ANT_ONE || ant_q == ANT_TWO)) begin
      if (ANT_GOOD_EVT) begin
        vote_q <= 4'h0;
      end else if (ANT_BAD_EVT) begin
        if (vote_q == 4'(ANT_VOTE_LIMIT - 1)) begin
          ant_q  <= (ant_q == ANT_ONE) ? ANT_TWO : ANT_ONE;
          vote_q <= 4'h0;
        end else begin
          vote_q <= vote_q + 4'h1;
        end
      end
    end
  end

  assign ANTENNA_VALID  = ant_q != ANT_INVALID && ant_q != ANT_NA;
  assign TX_ANTENNA     = (USE_DEFAULT_ANTENNA_FLAG && HOST_FRAME_TX) ? ant_q : ANT_INVALID;
  assign LISTEN_ANTENNA = FAST_DIVERSITY ? ANT_INVALID : ant_q;

  // ----------------------------------------
  // Beacon power save
  // ----------------------------------------
  wpcu_ps_t   ps_q;
  logic       woke_dtim_q;
  logic [7:0] tu_left_q;
  logic [31:0] tu_div_q;
  logic       tu_tick;
  logic       dtim_hit;
  logic       tim_hit;

  assign dtim_hit = timer_q[WK_TIME_HI:0] == dtim_cfg_q[WK_TIME_HI:0];
  assign tim_hit  = timer_q[WK_TIME_HI:0] == tim_cfg_q[WK_TIME_HI:0];
  assign tu_tick  = tu_div_q == 32'(TU_COUNT - 1);
  assign DTIM_WAKE = dtim_hit && !dtim_cfg_q[WK_SLEEP_EN];
  assign TIM_WAKE  = tim_hit && !dtim_cfg_q[WK_SLEEP_EN];

  // Wake times advance by interval in TU, i.e. eight eighth-TU steps
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dtim_cfg_q <= RST_DTIM_CFG;
      tim_cfg_q  <= RST_TIM_CFG & MSK_TIM_CFG;
    end else begin
      if (wr_dtim) begin
        dtim_cfg_q <= REG_WDATA & MSK_DTIM_CFG;
      end else if (dtim_hit) begin
        dtim_cfg_q[WK_TIME_HI:0] <= dtim_cfg_q[WK_TIME_HI:0]
                                    + {periods_q[31:PER_DTIM_LO], 3'h0};
      end
      if (wr_tim) begin
        tim_cfg_q <= REG_WDATA & MSK_TIM_CFG;
      end else if (tim_hit) begin
        tim_cfg_q[WK_TIME_HI:0] <= tim_cfg_q[WK_TIME_HI:0] + {periods_q[15:0], 3'h0};
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST || ps_q == WPCU_IDLE) begin
      tu_div_q <= 32'h0;
    end else begin
      tu_div_q <= tu_tick ? 32'h0 : tu_div_q + 32'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ps_q        <= WPCU_IDLE;
      woke_dtim_q <= 1'b0;
      tu_left_q   <= 8'h00;
    end else begin
      case (ps_q)
        WPCU_IDLE: begin
          if (DTIM_WAKE || TIM_WAKE) begin
            ps_q        <= WPCU_BCN;
            woke_dtim_q <= DTIM_WAKE;
            tu_left_q   <= tim_cfg_q[31:WK_LIMIT_LO];
          end
        end
        WPCU_BCN: begin
          if (BEACON_SEEN) begin
            ps_q      <= WPCU_CAB;
            tu_left_q <= dtim_cfg_q[31:WK_LIMIT_LO];
          end else if (tu_tick && tu_left_q <= 8'h1) begin
            ps_q      <= (woke_dtim_q && dtim_cfg_q[WK_PRESUME]) ? WPCU_CAB : WPCU_IDLE;
            tu_left_q <= dtim_cfg_q[31:WK_LIMIT_LO];
          end else if (tu_tick) begin
            tu_left_q <= tu_left_q - 8'h1;
          end
        end
        WPCU_CAB: begin
          if (CAB_SEEN) begin
            tu_left_q <= dtim_cfg_q[31:WK_LIMIT_LO];
          end else if (tu_tick && tu_left_q <= 8'h1) begin
            ps_q <= WPCU_IDLE;
          end else if (tu_tick) begin
            tu_left_q <= tu_left_q - 8'h1;
          end
        end
        default: ps_q <= WPCU_IDLE;
      endcase
    end
  end

  assign PS_STATE = ps_q;

  // ----------------------------------------
  // Statistics counters
  // ----------------------------------------
  logic [4:0]  cnt_evt;
  logic [4:0]  cnt_rd;
  logic [15:0] cnt_val [5];
  logic [15:0] cnt_ofs [5];

  assign cnt_evt = {BEACON_SEEN, CRC_FAIL_EVT, ACK_MISS_EVT, HS_FAIL_EVT, HS_OK_EVT};
  assign cnt_ofs = '{OFS_HS_OK, OFS_HS_FAIL, OFS_ACK_MISS, OFS_CRC_FAIL, OFS_BCN_CNT};

  for (genvar i = 0; i < 5; i++) begin : g_cnt
    assign cnt_rd[i] = REG_RD && REG_ADDR == cnt_ofs[i];
    wpcu_sat_counter #(.WIDTH(16)) u_cnt (
      .clk      (CLOCK),
      .srst     (SRST),
      .event_in (cnt_evt[i]),
      .rd_clear (cnt_rd[i]),
      .count_q  (cnt_val[i])
    );
  end

  // ----------------------------------------
  // Mask, power, read mux
  // ----------------------------------------
  assign ADDR_MATCH = (((RX_ADDR ^ OWN_ADDR) & {mask_high_q, mask_low_q}) == 48'h0);
  assign ACK_RESPONSE_POWER = pwr_q[5:0];
  assign CTS_RESPONSE_POWER = pwr_q[PWR_CTS_LO+5:PWR_CTS_LO];

  // Read data is registered: it shows the value before any clear-on-read
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        OFS_TIMER_LOW:  REG_RDATA <= timer_q[31:0];
        OFS_TIMER_HIGH: REG_RDATA <= timer_q[63:32];
        OFS_CONV_TEST:  REG_RDATA <= conv_q;
        OFS_DEF_ANT:    REG_RDATA <= {28'h0, ant_q};
        OFS_LAST_STAMP: REG_RDATA <= stamp_q;
        OFS_ALLOC_VEC:  REG_RDATA <= {6'h0, ALLOC_VECTOR};
        OFS_HS_OK:      REG_RDATA <= {16'h0, cnt_val[0]};
        OFS_HS_FAIL:    REG_RDATA <= {16'h0, cnt_val[1]};
        OFS_ACK_MISS:   REG_RDATA <= {16'h0, cnt_val[2]};
        OFS_CRC_FAIL:   REG_RDATA <= {16'h0, cnt_val[3]};
        OFS_BCN_CNT:    REG_RDATA <= {16'h0, cnt_val[4]};
        OFS_DTIM_CFG:   REG_RDATA <= dtim_cfg_q;
        OFS_TIM_CFG:    REG_RDATA <= tim_cfg_q;
        OFS_PERIODS:    REG_RDATA <= periods_q;
        OFS_MASK_LOW:   REG_RDATA <= mask_low_q;
        OFS_MASK_HIGH:  REG_RDATA <= {16'h0, mask_high_q};
        OFS_RESP_PWR:   REG_RDATA <= {18'h0, pwr_q};
        default:        REG_RDATA <= 32'h0;
      endcase
    end
  end
endmodule

// ==== src/wpcu_sat_counter.sv ====
module wpcu_sat_counter
  import wpcu_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             event_in,
  input  wire logic             rd_clear,
  output logic [WIDTH-1:0]      count_q
);
  if (WIDTH < 1) begin
    $error("WIDTH must be positive");
  end

  // Reading clears, but an event in the same cycle is kept as one
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (rd_clear) begin
      count_q <= event_in ? WIDTH'(1) : '0;
    end else if (event_in && count_q != {WIDTH{1'b1}}) begin
      count_q <= count_q + WIDTH'(1);
    end
  end
endmodule
